// >>> design/uart_autobaud_wake_break.v
// Purpose: auto-baud measurement, wake on break and break transmission
// Assumes: clk_i is the oscillator; Wishbone classic slave, 32-bit data
// Notes: the normal receive path is outside this block
`timescale 1ns/10ps
`default_nettype none
`include "uart_autobaud_consts.vh"

module uart_autobaud_wake_break (
	input wire clk_i,
	input wire rst_n_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire rx_i,
	output reg tx_o
);

// ****************************************
// Auto-baud states
// ****************************************
localparam AB_IDLE = 2'h0;
localparam AB_START = 2'h1;
localparam AB_FIRST = 2'h2;
localparam AB_COUNT = 2'h3;

reg autobaud_enable_r;
reg wake_on_break_enable_r;
reg send_break_request_r;
reg transmit_enable_bit_r;
reg wide_divisor_select_r;
reg high_speed_select_r;
reg receive_interrupt_flag_r;
reg autobaud_overflow_flag_r;
reg [7:0] baud_divisor_low_r;
reg [7:0] baud_divisor_high_r;
reg [1:0] ab_state_r;
reg [2:0] ab_edges_r;
reg [8:0] ab_pre_r;
reg wake_low_r;
reg hold_full_r;
reg hold_brk_r;
reg [7:0] hold_dat_r;
reg tx_busy_r;
reg tx_brk_r;
reg [13:0] tx_shift_r;
reg [3:0] tx_bits_r;
reg [22:0] tx_cnt_r;

wire rx_level;
wire rx_rise;
wire rx_fall;

rx_line_sync rx_sync (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.rx_i(rx_i),
	.level_o(rx_level),
	.rise_o(rx_rise),
	.fall_o(rx_fall)
);

// ****************************************
// Bus decode
// ****************************************
wire req = wb_cyc_i & wb_stb_i;
wire acc = req & wb_ack_o;
wire wr_acc = acc & wb_we_i & wb_sel_i[0];
wire rd_acc = acc & ~wb_we_i;
wire wr_ctrl = wr_acc & (wb_adr_i == `OFS_CTRL);
wire wr_stat = wr_acc & (wb_adr_i == `OFS_STATUS);
wire wr_lo = wr_acc & (wb_adr_i == `OFS_DIV_LOW);
wire wr_hi = wr_acc & (wb_adr_i == `OFS_DIV_HIGH);
wire wr_tx = wr_acc & (wb_adr_i == `OFS_TX_DATA);
wire rd_rx = rd_acc & (wb_adr_i == `OFS_RX_DATA);

// ****************************************
// Baud timing
// ****************************************
reg [2:0] base_shift;
reg [8:0] abd_div_m1;
always @* begin
	if (wide_divisor_select_r & high_speed_select_r) begin
		base_shift = `BASE_SHIFT_FAST;
		abd_div_m1 = `ABD_DIV_FAST_M1;
	end else if (wide_divisor_select_r | high_speed_select_r) begin
		base_shift = `BASE_SHIFT_MID;
		abd_div_m1 = `ABD_DIV_MID_M1;
	end else begin
		base_shift = `BASE_SHIFT_SLOW;
		abd_div_m1 = `ABD_DIV_SLOW_M1;
	end
end

// Eight-bit mode ignores the high byte for timing
wire [15:0] div_sel = wide_divisor_select_r ?
	{baud_divisor_high_r, baud_divisor_low_r} :
	{8'h00, baud_divisor_low_r};
wire [22:0] div_p1 = {7'h00, div_sel} + 23'h00_0001;
wire [22:0] bit_period = div_p1 << base_shift;
wire [22:0] bit_period_m1 = bit_period - 23'h00_0001;

// ****************************************
// Auto-baud measurement
// ****************************************
wire ab_tick = (ab_state_r == AB_COUNT) & (ab_pre_r == abd_div_m1);
wire [16:0] ab_inc = {1'b0, baud_divisor_high_r, baud_divisor_low_r} +
	17'h0_0001;
wire ab_done = (ab_state_r == AB_COUNT) & rx_rise &
	(ab_edges_r == `ABD_LAST_EDGE);
wire ab_ovf = ab_tick & ab_inc[16];
wire ab_first = (ab_state_r == AB_FIRST) & rx_rise;

always @(posedge clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		ab_state_r <= AB_IDLE;
		ab_edges_r <= 3'h0;
		ab_pre_r <= 9'h000;
	end else if (!autobaud_enable_r) begin
		// Software clearing the enable aborts at once
		ab_state_r <= AB_IDLE;
	end else begin
		case (ab_state_r)
		AB_IDLE: begin
			// Measurement waits until the break has ended
			if (!wake_on_break_enable_r) begin
				ab_state_r <= AB_START;
			end
		end
		AB_START: begin
			if (rx_fall) begin
				ab_state_r <= AB_FIRST;
			end
		end
		AB_FIRST: begin
			if (rx_rise) begin
				ab_state_r <= AB_COUNT;
				ab_edges_r <= 3'h1;
				ab_pre_r <= 9'h000;
			end
		end
		AB_COUNT: begin
			ab_pre_r <= ab_tick ? 9'h000 : ab_pre_r + 9'h001;
			if (rx_rise) begin
				ab_edges_r <= ab_edges_r + 3'h1;
			end
			if (ab_done) begin
				ab_state_r <= AB_IDLE;
			end
		end
		default: begin
			ab_state_r <= AB_IDLE;
		end
		endcase
	end
end

// ****************************************
// Control, status and divisor registers
// ****************************************
wire wake_fall = wake_on_break_enable_r & rx_fall & ~wake_low_r;
wire wake_end = wake_on_break_enable_r & rx_rise & wake_low_r;
wire tx_last = tx_busy_r & (tx_cnt_r == 23'h00_0000) &
	(tx_bits_r == 4'h0);
wire brk_done = tx_last & tx_brk_r;

always @(posedge clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		autobaud_enable_r <= 1'b0;
		wake_on_break_enable_r <= 1'b0;
		send_break_request_r <= 1'b0;
		transmit_enable_bit_r <= 1'b0;
		wide_divisor_select_r <= 1'b0;
		high_speed_select_r <= 1'b0;
		receive_interrupt_flag_r <= 1'b0;
		autobaud_overflow_flag_r <= 1'b0;
		baud_divisor_low_r <= 8'h00;
		baud_divisor_high_r <= 8'h00;
		wake_low_r <= 1'b0;
	end else begin
		if (wr_ctrl) begin
			autobaud_enable_r <= wb_dat_i[`CTRL_AUTOBAUD];
			wake_on_break_enable_r <= wb_dat_i[`CTRL_WAKE];
			send_break_request_r <= wb_dat_i[`CTRL_SEND_BREAK];
			transmit_enable_bit_r <= wb_dat_i[`CTRL_TX_ENABLE];
			wide_divisor_select_r <= wb_dat_i[`CTRL_WIDE_DIV];
			high_speed_select_r <= wb_dat_i[`CTRL_HIGH_SPEED];
		end else begin
			if (ab_done) begin
				autobaud_enable_r <= 1'b0;
			end
			if (wake_end) begin
				wake_on_break_enable_r <= 1'b0;
			end
			if (brk_done) begin
				send_break_request_r <= 1'b0;
			end
		end
		// Wake watcher: falling edge wakes, rising edge ends break
		if (!wake_on_break_enable_r || wake_end) begin
			wake_low_r <= 1'b0;
		end else if (wake_fall) begin
			wake_low_r <= 1'b1;
		end
		// Hardware set wins over the read that clears
		if (ab_done || wake_fall) begin
			receive_interrupt_flag_r <= 1'b1;
		end else if (rd_rx) begin
			receive_interrupt_flag_r <= 1'b0;
		end
		if (ab_ovf) begin
			autobaud_overflow_flag_r <= 1'b1;
		end else if (wr_stat && wb_dat_i[`STAT_AB_OVF] &&
			!autobaud_enable_r) begin
			autobaud_overflow_flag_r <= 1'b0;
		end
		// Divisor pair doubles as the 16-bit measuring counter
		if (ab_first) begin
			baud_divisor_high_r <= 8'h00;
			baud_divisor_low_r <= 8'h01;
		end else if (ab_tick) begin
			baud_divisor_high_r <= ab_inc[15:8];
			baud_divisor_low_r <= ab_inc[7:0];
		end else if (ab_state_r != AB_COUNT) begin
			if (wr_lo) begin
				baud_divisor_low_r <= wb_dat_i[7:0];
			end
			if (wr_hi) begin
				baud_divisor_high_r <= wb_dat_i[7:0];
			end
		end
	end
end

// ****************************************
// Transmitter with one-byte hold buffer
// ****************************************
wire brk_pending = (hold_full_r & hold_brk_r) | (tx_busy_r & tx_brk_r);
// A held frame loads on the stop bit's last edge, so back-to-back bits stay P
wire tx_load = hold_full_r & transmit_enable_bit_r & (~tx_busy_r | tx_last);
wire [13:0] tx_frame = hold_brk_r ? `BREAK_FRAME :
	{5'h1f, hold_dat_r, 1'b0};

always @(posedge clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		hold_full_r <= 1'b0;
		hold_brk_r <= 1'b0;
		hold_dat_r <= 8'h00;
		tx_busy_r <= 1'b0;
		tx_brk_r <= 1'b0;
		tx_shift_r <= 14'h0000;
		tx_bits_r <= 4'h0;
		tx_cnt_r <= 23'h00_0000;
		tx_o <= 1'b1;
	end else begin
		if (tx_busy_r) begin
			if (tx_cnt_r != 23'h00_0000) begin
				tx_cnt_r <= tx_cnt_r - 23'h00_0001;
			end else if (tx_bits_r == 4'h0) begin
				// Stop bit done; a held byte loads on this same edge
				tx_busy_r <= 1'b0;
				tx_brk_r <= 1'b0;
			end else begin
				tx_o <= tx_shift_r[0];
				tx_shift_r <= tx_shift_r >> 1;
				tx_bits_r <= tx_bits_r - 4'h1;
				tx_cnt_r <= bit_period_m1;
			end
		end
		// Last in the block so a load overrides the stop-bit clear
		if (tx_load) begin
			hold_full_r <= 1'b0;
			tx_busy_r <= 1'b1;
			tx_brk_r <= hold_brk_r;
			tx_shift_r <= tx_frame >> 1;
			tx_bits_r <= hold_brk_r ? `BREAK_BITS_M1 :
				`CHAR_BITS_M1;
			tx_cnt_r <= bit_period_m1;
			tx_o <= 1'b0;
		end else if (wr_tx && !hold_full_r) begin
			// Only the first write while send-break is set is a break
			hold_full_r <= 1'b1;
			hold_brk_r <= send_break_request_r & transmit_enable_bit_r &
				~brk_pending;
			hold_dat_r <= wb_dat_i[7:0];
		end
	end
end

// ****************************************
// Read mux and acknowledge
// ****************************************
wire rx_idle = (ab_state_r == AB_IDLE) & rx_level & ~wake_low_r;
reg [31:0] rd_val;
always @* begin
	rd_val = 32'h0000_0000;
	case (wb_adr_i)
	`OFS_CTRL: begin
		rd_val[`CTRL_AUTOBAUD] = autobaud_enable_r;
		rd_val[`CTRL_WAKE] = wake_on_break_enable_r;
		rd_val[`CTRL_SEND_BREAK] = send_break_request_r;
		rd_val[`CTRL_TX_ENABLE] = transmit_enable_bit_r;
		rd_val[`CTRL_WIDE_DIV] = wide_divisor_select_r;
		rd_val[`CTRL_HIGH_SPEED] = high_speed_select_r;
	end
	`OFS_STATUS: begin
		rd_val[`STAT_RX_FLAG] = receive_interrupt_flag_r;
		rd_val[`STAT_AB_OVF] = autobaud_overflow_flag_r;
		rd_val[`STAT_RX_IDLE] = rx_idle;
		rd_val[`STAT_SHIFT_EMPTY] = ~tx_busy_r;
		rd_val[`STAT_TX_EMPTY] = ~hold_full_r;
	end
	`OFS_DIV_LOW: begin
		rd_val[7:0] = baud_divisor_low_r;
	end
	`OFS_DIV_HIGH: begin
		rd_val[7:0] = baud_divisor_high_r;
	end
	default: begin
		rd_val = 32'h0000_0000;
	end
	endcase
end

// Single-cycle answer; unmapped addresses ack with zero
always @(posedge clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h0000_0000;
	end else begin
		wb_ack_o <= req & ~wb_ack_o;
		if (req && !wb_ack_o) begin
			wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_val;
		end
	end
end

endmodule
`default_nettype wire

// >>> design/uart_autobaud_consts.vh
// Purpose: constants for the auto-baud, wake and break transceiver block
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes: all registers hold their data in the low byte
`ifndef UART_AUTOBAUD_CONSTS_VH
`define UART_AUTOBAUD_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_DIV_LOW 8'h08
`define OFS_DIV_HIGH 8'h0c
`define OFS_RX_DATA 8'h10
`define OFS_TX_DATA 8'h14

// ****************************************
// Control bits
// ****************************************
`define CTRL_AUTOBAUD 0
`define CTRL_WAKE 1
`define CTRL_SEND_BREAK 2
`define CTRL_TX_ENABLE 3
`define CTRL_WIDE_DIV 4
`define CTRL_HIGH_SPEED 5

// ****************************************
// Status bits
// ****************************************
`define STAT_RX_FLAG 0
`define STAT_AB_OVF 1
`define STAT_FRAMING 2
`define STAT_RX_IDLE 3
`define STAT_SHIFT_EMPTY 4
`define STAT_TX_EMPTY 5

// ****************************************
// Prescale ratios and frames
// ****************************************
`define BASE_SHIFT_FAST 3'h2
`define BASE_SHIFT_MID 3'h4
`define BASE_SHIFT_SLOW 3'h6
`define ABD_DIV_FAST_M1 9'h01f
`define ABD_DIV_MID_M1 9'h07f
`define ABD_DIV_SLOW_M1 9'h1ff
`define BREAK_FRAME 14'h2000
`define BREAK_BITS_M1 4'hd
`define CHAR_BITS_M1 4'h9
`define ABD_LAST_EDGE 3'h4

`endif

// >>> design/rx_line_sync.v
// Purpose: bring the receive pin into the clock domain and find its edges
// Assumes: rx idles high
// Notes: edges are one-cycle pulses, one to two cycles behind the pin
`timescale 1ns/10ps
`default_nettype none

module rx_line_sync (
	input wire clk_i,
	input wire rst_n_i,
	input wire rx_i,
	output wire level_o,
	output wire rise_o,
	output wire fall_o
);

reg meta_r;
reg sync_r;
reg prev_r;

// First stage feeds only the second
always @(posedge clk_i or negedge rst_n_i) begin
	if (!rst_n_i) begin
		meta_r <= 1'b1;
		sync_r <= 1'b1;
		prev_r <= 1'b1;
	end else begin
		meta_r <= rx_i;
		sync_r <= meta_r;
		prev_r <= sync_r;
	end
end

assign level_o = sync_r;
assign rise_o = sync_r & ~prev_r;
assign fall_o = ~sync_r & prev_r;

endmodule
`default_nettype wire

// >>> testbench/uart_abw_monitor.sv
// Purpose: port-level checks on the bus and the transmit line
// Assumes: one clock domain, reset active low
// Notes: bound into the block below the module
`timescale 1ns/10ps
`default_nettype none
module uart_abw_monitor (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic tx_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_after_req: assert property (s_req |=> s_ack_pulse)
		else $error("ack not a pulse one cycle after request");
	a_ack_only_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without a request");
	a_rd_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 0)
		else $error("upper read bits not zero");
	a_wr_dat_zero: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 0)
		else $error("write answered with data");
	a_rxdata_zero: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i == 8'h10 |-> wb_dat_o == 0)
		else $error("receive data read not zero");
	a_stat_rsvd: assert property (
		wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |-> wb_dat_o[7:6] == 0)
		else $error("reserved status bits set");
	a_ack_dat_hold: assert property ($fell(wb_ack_o) |-> $stable(wb_dat_o))
		else $error("read data dropped with ack");
	a_tx_low_min: assert property ($fell(tx_o) |-> !tx_o [*4])
		else $error("tx low shorter than a bit");
	a_tx_high_min: assert property ($rose(tx_o) |-> tx_o [*4])
		else $error("tx high shorter than a bit");
	a_tx_idle_rst: assert property ($rose(rst_n_i) |-> tx_o && !wb_ack_o)
		else $error("tx not idle after reset");
endmodule
bind uart_autobaud_wake_break uart_abw_monitor i_mon (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.tx_o(tx_o)
);
`default_nettype wire

// >>> testbench/lin_node_model.sv
// Purpose: remote serial node driving the receive line
// Assumes: bit time given in clocks, calls start just after an edge
// Notes: line rests high between frames
`timescale 1ns/10ps
`default_nettype none
module lin_node_model (
	input wire logic clk_i,
	output logic rx_o
);
	initial rx_o = 1'b1;
	task automatic bit_out(input logic v, input int t);
		rx_o <= v;
		repeat (t) @(posedge clk_i);
	endtask
	task automatic send_byte(input logic [7:0] d, input int t);
		bit_out(1'b0, t);
		for (int i = 0; i < 8; i++) bit_out(d[i], t);
		bit_out(1'b1, t);
	endtask
	// All-zero wake character, long enough to avoid fragments
	task automatic send_break(input int n, input int t);
		bit_out(1'b0, n * t);
		bit_out(1'b1, t);
	endtask
endmodule
`default_nettype wire

// >>> testbench/uart_autobaud_wake_break_tb.sv
// Purpose: self-checking bench for auto-baud, wake and break
// Assumes: 125 MHz clock, bus answers one cycle after a request
// Notes: overflow needs over a million cycles, so it is not run
`timescale 1ns/10ps
`default_nettype none
module uart_autobaud_wake_break_tb;
	typedef struct packed {logic w; logic [3:0] s; logic [7:0] a;
		logic [7:0] d;} row_t;
	logic clk_i, rst_n_i, cyc, stb, we, rx, tx, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, dat_o;
	int miscompares = 0, n_compared = 0, cycles = 0, n;
	row_t rows[12] = '{'{1'b0, 4'hf, 8'h04, 8'h38}, '{1'b0, 4'hf, 8'h00, 8'h00},
		'{1'b0, 4'hf, 8'h08, 8'h00}, '{1'b1, 4'hf, 8'h08, 8'h5a},
		'{1'b1, 4'he, 8'h08, 8'ha5}, '{1'b0, 4'hf, 8'h08, 8'h5a},
		'{1'b1, 4'hf, 8'h0c, 8'hc3}, '{1'b0, 4'hf, 8'h0c, 8'hc3},
		'{1'b0, 4'hf, 8'h1c, 8'h00}, '{1'b0, 4'hf, 8'h10, 8'h00},
		'{1'b1, 4'hf, 8'h00, 8'h30}, '{1'b0, 4'hf, 8'h00, 8'h30}};
	uart_autobaud_wake_break i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.rx_i(rx), .tx_o(tx));
	lin_node_model i_node (.clk_i(clk_i), .rx_o(rx));
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Ceiling well above the roughly 60k cycles the tests need
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			miscompares++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic xfer(input logic w, input logic [3:0] s,
		input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= s;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, 4'hf, a, {24'h00_0000, d});
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, 4'hf, a, 32'h0000_0000);
		chk(rdat, {24'h00_0000, e});
	endtask
	// Count of 1 plus one tick per 8 base clocks over 8 bit times
	task automatic calib(input logic [7:0] c, input int t, input logic [15:0] e);
		i_node.send_byte(8'h55, t);
		repeat (8) @(posedge clk_i);
		rd(8'h0c, e[15:8]);
		rd(8'h08, e[7:0]);
		rd(8'h00, c & 8'hfe);
		rd(8'h04, 8'h39);
		rd(8'h10, 8'h00);
		rd(8'h04, 8'h38);
		$display("test calibration %h done", c);
	endtask
	task automatic run_len(output int k);
		logic l;
		l = tx;
		k = 0;
		while (tx === l && k < 4000) begin
			@(posedge clk_i);
			k++;
		end
	endtask
	initial begin
		{cyc, stb, we, adr, sel, wdat} = '0;
		rst_n_i = 1'b0;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		foreach (rows[i])
			if (rows[i].w)
				xfer(1'b1, rows[i].s, rows[i].a, {24'h00_0000, rows[i].d});
			else
				rd(rows[i].a, rows[i].d);
		$display("test registers done");
		wr(8'h00, 8'h31);
		calib(8'h31, 256, 16'h0041);
		wr(8'h00, 8'h21);
		calib(8'h21, 4160, 16'h0105);
		wr(8'h00, 8'h11);
		calib(8'h11, 128, 16'h0009);
		wr(8'h00, 8'h01);
		calib(8'h01, 512, 16'h0009);
		rd(8'h04, 8'h38);
		wr(8'h00, 8'h33);
		i_node.send_break(13, 256);
		repeat (8) @(posedge clk_i);
		// Measurement is armed and waiting, so receive idle reads low
		rd(8'h04, 8'h31);
		rd(8'h00, 8'h31);
		rd(8'h10, 8'h00);
		rd(8'h04, 8'h30);
		calib(8'h31, 256, 16'h0041);
		wr(8'h08, 8'h03);
		wr(8'h00, 8'h3c);
		fork
			begin
				wr(8'h14, 8'hff);
				wr(8'h14, 8'h55);
			end
			begin
				while (tx !== 1'b0) @(posedge clk_i);
				for (int k = 0; k < 11; k++) begin
					run_len(n);
					chk(n, k == 0 ? 208 : 16);
				end
			end
		join
		repeat (40) @(posedge clk_i);
		rd(8'h00, 8'h38);
		rd(8'h04, 8'h38);
		$display("test break done");
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(8'h00, 8'h00);
		rd(8'h08, 8'h00);
		$display("test reset done");
		complete_run();
	end
endmodule
`default_nettype wire
